/* logic/fswp_core.sv */
/*
 * Status bits and write protection of a serial NOR flash: holds the
 * protection, lock, quad, security-lock, suspend and drive bits, and
 * judges status writes, programs and erases.
 * Assumes an upstream decoder that issues one opcode per cmd_valid
 * pulse, with address and first data byte, and an array engine that
 * acts on pe_go.
 */
// Overview of operation
// - Select bits writable only by status write
// - Refuse program or erase inside guarded region
// - Hardware lock keeps select bits unchanged while guard pin low and quad off
// - Chip erase only for all-zero or all-one
// - Quad enable turns guard pins into data
// - Quad command mode needs quad enable first
// - Quad command mode keeps quad enable set
// - Security-lock bits set once, never clear
// - Invert bit writable, default zero
// - Suspend sets program or erase pause flag, resume clears both
// - Drive field picks output strength
// - Software lock needs write-arm latch
// - Hardware lock follows write-guard pin
// - Supply lock until power cycle clears it
// - Permanent lock refuses all status writes
// - Deep power-down accepts only release
// - Write-arm latch set and cleared properly
// - Block-size region map, top or bottom
// - Sector-size region map, top or bottom
// - Invert bit complements guarded region
// - No write without write-arm latch
module fswp_core (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Decoded commands
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_op,
    input  wire logic [20:0] cmd_addr,
    input  wire logic [7:0]  cmd_data,
    // Device conditions
    input  wire logic        pwr_cycle,
    input  wire logic        wp_n,
    input  wire logic        engine_busy,
    input  wire logic        program_active,
    // Status and pin roles
    output logic      [23:0] status_word,
    output logic             quad_pins_on,
    output logic             four_wire_command_mode,
    output logic      [1:0]  drive_level,
    output logic             deep_power_down,
    output logic      [2:0]  secreg_read_only,
    // Verdicts
    output logic             pe_go,
    output logic             pe_refused,
    output logic             sr_accepted,
    output logic             sr_refused
);
    typedef struct packed {
        logic [4:0]  bp;
        logic        invert;
        logic [1:0]  lock_mode;
        logic        quad_on;
        logic [2:0]  lb;
        logic [1:0]  drv;
        logic        arm;
        logic        erase_paused;
        logic        program_paused;
        logic        qcmd;
        logic        dpd;
        logic        rst_armed;
        logic        pe_go;
        logic        pe_refused;
        logic        sr_accepted;
        logic        sr_refused;
        logic [23:0] status;
    } fswp_state_type;

    fswp_state_type s;
    fswp_state_type next_s;

    fswp_ctl_if ctl ();

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    fswp_range u_range (.ctl(ctl.range_mp));
    fswp_gate  u_gate  (.ctl(ctl.gate_mp));

    assign ctl.bp        = s.bp;
    assign ctl.lock_mode = s.lock_mode;
    assign ctl.wp_n      = wp_n;
    assign ctl.quad_on   = s.quad_on;
    assign ctl.arm       = s.arm;

    // ------------------------------------------------------------------
    // Target overlap against the guarded range
    // ------------------------------------------------------------------
    logic        is_wrsr;
    logic        is_pe;
    logic        is_ce;
    logic [4:0]  op_log;
    logic [20:0] op_mask;
    logic [20:0] op_start;
    logic [20:0] op_end;
    logic        base_hit;
    logic        base_holds;
    logic        hit;
    logic        ce_ok;

    assign is_wrsr = cmd_op == fswp_pkg::OP_WRSR1
                  || cmd_op == fswp_pkg::OP_WRSR2
                  || cmd_op == fswp_pkg::OP_WRSR3;
    assign is_ce   = cmd_op == fswp_pkg::OP_CE_A
                  || cmd_op == fswp_pkg::OP_CE_B;
    assign is_pe   = cmd_op == fswp_pkg::OP_PP || cmd_op == fswp_pkg::OP_QPP
                  || cmd_op == fswp_pkg::OP_SE
                  || cmd_op == fswp_pkg::OP_BE32
                  || cmd_op == fswp_pkg::OP_BE64;

    assign op_log = (cmd_op == fswp_pkg::OP_SE)   ? fswp_pkg::SE_LOG :
                    (cmd_op == fswp_pkg::OP_BE32) ? fswp_pkg::BE32_LOG :
                    (cmd_op == fswp_pkg::OP_BE64) ? fswp_pkg::BE64_LOG :
                                                    fswp_pkg::PP_LOG;
    assign op_mask  = 21'((22'h1 << op_log) - 22'h1);
    assign op_start = cmd_addr & ~op_mask;
    assign op_end   = op_start | op_mask;

    // Whole span compared, so a large erase touching the edge is caught
    assign base_hit   = !ctl.none && op_start <= ctl.hi
                                  && op_end >= ctl.lo;
    assign base_holds = !ctl.none && op_start >= ctl.lo
                                  && op_end <= ctl.hi;
    assign hit = s.invert ? !base_holds : base_hit;
    assign ce_ok = (s.bp[2:0] == 3'h0 && !s.invert)
                || (s.bp[2:0] == 3'h7 && s.invert);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_s             = s;
        next_s.pe_go       = 1'b0;
        next_s.pe_refused  = 1'b0;
        next_s.sr_accepted = 1'b0;
        next_s.sr_refused  = 1'b0;
        if (pwr_cycle) begin
            next_s.arm            = 1'b0;
            next_s.erase_paused   = 1'b0;
            next_s.program_paused = 1'b0;
            next_s.qcmd           = 1'b0;
            next_s.dpd            = 1'b0;
            next_s.rst_armed      = 1'b0;
            if (s.lock_mode == fswp_pkg::LOCK_PSU) begin
                next_s.lock_mode = fswp_pkg::LOCK_SW;
            end
        end else if (cmd_valid && s.dpd) begin
            if (cmd_op == fswp_pkg::OP_WAKE) begin
                next_s.dpd = 1'b0;
            end
        end else if (cmd_valid) begin
            next_s.rst_armed = (cmd_op == fswp_pkg::OP_RST_EN);
            if (is_wrsr) begin
                next_s.arm = 1'b0;
                if (ctl.sr_wr_ok) begin
                    next_s.sr_accepted = 1'b1;
                    if (cmd_op == fswp_pkg::OP_WRSR1) begin
                        next_s.bp = cmd_data[fswp_pkg::B1_SEL0 +: 5];
                        next_s.lock_mode[0] = cmd_data[fswp_pkg::B1_LOCK0];
                    end else if (cmd_op == fswp_pkg::OP_WRSR2) begin
                        next_s.lock_mode[1] = cmd_data[fswp_pkg::B2_LOCK1];
                        // Quad mode pins the enable high
                        next_s.quad_on = cmd_data[fswp_pkg::B2_QUAD]
                                         || s.qcmd;
                        next_s.lb = s.lb
                                  | cmd_data[fswp_pkg::B2_SECL +: 3];
                        next_s.invert = cmd_data[fswp_pkg::B2_INV];
                    end else begin
                        next_s.drv =
                            cmd_data[fswp_pkg::B3_DRIVE +: 2];
                    end
                end else begin
                    next_s.sr_refused = 1'b1;
                end
            end else if (is_pe || is_ce) begin
                next_s.arm = 1'b0;
                if (s.arm && (is_ce ? ce_ok : !hit)) begin
                    next_s.pe_go = 1'b1;
                end else begin
                    next_s.pe_refused = 1'b1;
                end
            end else begin
                case (cmd_op)
                    fswp_pkg::OP_WREN:     next_s.arm = 1'b1;
                    fswp_pkg::OP_WRDI:     next_s.arm = 1'b0;
                    fswp_pkg::OP_SUSPEND: begin
                        if (program_active) begin
                            next_s.program_paused = 1'b1;
                        end else begin
                            next_s.erase_paused = 1'b1;
                        end
                    end
                    fswp_pkg::OP_RESUME: begin
                        next_s.erase_paused   = 1'b0;
                        next_s.program_paused = 1'b0;
                    end
                    fswp_pkg::OP_SLEEP:    next_s.dpd = 1'b1;
                    fswp_pkg::OP_QUAD_ON:  next_s.qcmd = s.quad_on;
                    fswp_pkg::OP_QUAD_OFF: next_s.qcmd = 1'b0;
                    fswp_pkg::OP_RST: begin
                        if (s.rst_armed) begin
                            next_s.arm = 1'b0;
                            next_s.qcmd = 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
        end
        next_s.status = {1'b0, next_s.drv, 5'h00,
                         next_s.erase_paused, next_s.invert, next_s.lb,
                         next_s.program_paused, next_s.quad_on,
                         next_s.lock_mode, next_s.bp, next_s.arm,
                         engine_busy};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s           <= '0;
            s.bp        <= fswp_pkg::BP_RST;
            s.lock_mode <= fswp_pkg::LOCK_RST;
            s.drv       <= fswp_pkg::DRV_RST;
            s.lb        <= fswp_pkg::LB_RST;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign status_word            = s.status;
    assign quad_pins_on           = s.quad_on;
    assign four_wire_command_mode = s.qcmd;
    assign drive_level            = s.drv;
    assign deep_power_down        = s.dpd;
    assign secreg_read_only       = s.lb;
    assign pe_go                  = s.pe_go;
    assign pe_refused             = s.pe_refused;
    assign sr_accepted            = s.sr_accepted;
    assign sr_refused             = s.sr_refused;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_sr_needs_arm: assert property (
        sr_accepted |-> $past(s.arm) && !$past(pwr_cycle))
        else $error("status write taken without write-arm latch");

    a_hw_lock_block: assert property (
        cmd_valid && is_wrsr && !s.dpd && !pwr_cycle && !wp_n
        && !s.quad_on && s.lock_mode == fswp_pkg::LOCK_HW
        |=> sr_refused && $stable(s.bp))
        else $error("status write passed a low write guard");

    a_psu_lock_hold: assert property (
        s.lock_mode == fswp_pkg::LOCK_PSU && !pwr_cycle
        |=> s.lock_mode == fswp_pkg::LOCK_PSU && !sr_accepted)
        else $error("supply lock left without power cycle");

    a_otp_lock_perm: assert property (
        s.lock_mode == fswp_pkg::LOCK_OTP
        |=> s.lock_mode == fswp_pkg::LOCK_OTP && !sr_accepted)
        else $error("permanent lock changed or bypassed");

    a_lb_sticky: assert property (
        ($past(s.lb) & ~s.lb) == 3'h0)
        else $error("security lock bit cleared");

    a_quad_held: assert property (
        four_wire_command_mode |-> quad_pins_on)
        else $error("quad enable low in four-wire mode");

    a_quad_entry: assert property (
        $rose(s.qcmd) |-> $past(s.quad_on))
        else $error("four-wire mode entered without quad enable");

    a_ce_gate: assert property (
        cmd_valid && is_ce && !s.dpd && !pwr_cycle && s.arm && !ce_ok
        |=> pe_refused && !pe_go && !s.arm)
        else $error("chip erase allowed under protection");

    a_dpd_ignore: assert property (
        s.dpd && cmd_valid && cmd_op != fswp_pkg::OP_WAKE && !pwr_cycle
        |=> s.dpd && !pe_go && !sr_accepted && $stable(s.arm))
        else $error("command acted on in deep power-down");

    a_pe_guard: assert property (
        cmd_valid && is_pe && !s.dpd && !pwr_cycle && hit
        |=> pe_refused ##1 !pe_go)
        else $error("program or erase hit a guarded target");

    a_arm_release: assert property (
        cmd_valid && (is_pe || is_ce || is_wrsr) && !pwr_cycle && !s.dpd
        |=> !s.arm)
        else $error("write-arm latch kept after write command");

    c_sr_write:   cover property (sr_accepted);
    c_pe_refused: cover property (pe_refused);
    c_quad_mode:  cover property ($rose(four_wire_command_mode));
    c_paused:     cover property ($rose(s.erase_paused));
endmodule

/* logic/fswp_ctl_if.sv */
/*
 * Carrier between the protection core and its two helpers.
 * Assumes all members are driven combinationally within one clock.
 */
interface fswp_ctl_if;
    logic [4:0]  bp;
    logic [20:0] lo;
    logic [20:0] hi;
    logic        none;
    logic [1:0]  lock_mode;
    logic        wp_n;
    logic        quad_on;
    logic        arm;
    logic        sr_wr_ok;

    modport range_mp (input bp, output lo, hi, none);
    modport gate_mp  (input lock_mode, wp_n, quad_on, arm, output sr_wr_ok);
    modport core_mp  (output bp, lock_mode, wp_n, quad_on, arm,
                      input lo, hi, none, sr_wr_ok);
endinterface

/* logic/fswp_gate.sv */
/*
 * Decides whether a status write may be taken under the lock mode.
 * Assumes the write-guard level is valid only while quad pins are off.
 */
module fswp_gate (
    // Lock inputs, verdict out
    fswp_ctl_if.gate_mp ctl
);
    logic guard_high;

    // With quad pins on the guard pin is data line 2, never a guard
    assign guard_high = ctl.wp_n || ctl.quad_on;

    always_comb begin
        unique case (ctl.lock_mode)
            fswp_pkg::LOCK_SW:  ctl.sr_wr_ok = ctl.arm;
            fswp_pkg::LOCK_HW:  ctl.sr_wr_ok = ctl.arm
                                               && guard_high;
            fswp_pkg::LOCK_PSU: ctl.sr_wr_ok = 1'b0;
            fswp_pkg::LOCK_OTP: ctl.sr_wr_ok = 1'b0;
        endcase
    end
endmodule

/* logic/fswp_pkg.sv */
/*
 * Shared constants for the flash status-bit and write-protection block:
 * opcodes, status bit positions, lock modes, reset values, erase sizes.
 * Assumes an upstream command decoder hands over whole opcodes.
 */
package fswp_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 21;
    localparam int SR_W   = 24;

    // ------------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_WREN     = 8'h06;
    localparam logic [7:0] OP_WRDI     = 8'h04;
    localparam logic [7:0] OP_WRSR1    = 8'h01;
    localparam logic [7:0] OP_WRSR2    = 8'h31;
    localparam logic [7:0] OP_WRSR3    = 8'h11;
    localparam logic [7:0] OP_PP       = 8'h02;
    localparam logic [7:0] OP_QPP      = 8'h32;
    localparam logic [7:0] OP_SE       = 8'h20;
    localparam logic [7:0] OP_BE32     = 8'h52;
    localparam logic [7:0] OP_BE64     = 8'hD8;
    localparam logic [7:0] OP_CE_A     = 8'hC7;
    localparam logic [7:0] OP_CE_B     = 8'h60;
    localparam logic [7:0] OP_SUSPEND  = 8'h75;
    localparam logic [7:0] OP_RESUME   = 8'h7A;
    localparam logic [7:0] OP_SLEEP    = 8'hB9;
    localparam logic [7:0] OP_WAKE     = 8'hAB;
    localparam logic [7:0] OP_QUAD_ON  = 8'h38;
    localparam logic [7:0] OP_QUAD_OFF = 8'hFF;
    localparam logic [7:0] OP_RST_EN   = 8'h66;
    localparam logic [7:0] OP_RST      = 8'h99;

    // ------------------------------------------------------------------
    // Status byte field positions within each written byte
    // ------------------------------------------------------------------
    localparam int B1_SEL0  = 2;
    localparam int B1_LOCK0 = 7;
    localparam int B2_LOCK1 = 0;
    localparam int B2_QUAD  = 1;
    localparam int B2_SECL  = 3;
    localparam int B2_INV   = 6;
    localparam int B3_DRIVE = 5;

    // ------------------------------------------------------------------
    // Lock modes and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] LOCK_SW  = 2'h0;
    localparam logic [1:0] LOCK_HW  = 2'h1;
    localparam logic [1:0] LOCK_PSU = 2'h2;
    localparam logic [1:0] LOCK_OTP = 2'h3;

    localparam logic [4:0] BP_RST   = 5'h00;
    localparam logic [1:0] LOCK_RST = 2'h0;
    localparam logic [1:0] DRV_RST  = 2'h0;
    localparam logic [2:0] LB_RST   = 3'h0;

    // ------------------------------------------------------------------
    // Region and operation sizes as log2 of bytes
    // ------------------------------------------------------------------
    localparam logic [4:0] BLK_BASE_LOG = 5'h0F;
    localparam logic [4:0] SEC_BASE_LOG = 5'h0B;
    localparam logic [4:0] PP_LOG       = 5'h08;
    localparam logic [4:0] SE_LOG       = 5'h0C;
    localparam logic [4:0] BE32_LOG     = 5'h0F;
    localparam logic [4:0] BE64_LOG     = 5'h10;

endpackage

/* logic/fswp_range.sv */
/*
 * Decodes the five protect-select bits into the base guarded range.
 * Assumes a 2 MB array; the invert bit is applied by the caller.
 */
module fswp_range (
    // Select bits in, range out
    fswp_ctl_if.range_mp ctl
);
    logic [4:0]  k;
    logic [20:0] mask;
    logic        full;

    always_comb begin
        k    = 5'h00;
        full = (ctl.bp[2:1] == 2'h3);
        ctl.none = (ctl.bp[2:0] == 3'h0);
        if (!ctl.bp[4]) begin
            k = fswp_pkg::BLK_BASE_LOG + {2'h0, ctl.bp[2:0]};
        end else if (ctl.bp[2]) begin
            k = fswp_pkg::SEC_BASE_LOG + 5'h04;
        end else begin
            k = fswp_pkg::SEC_BASE_LOG + {2'h0, ctl.bp[2:0]};
        end
        mask = full ? {21{1'b1}} : 21'((22'h1 << k) - 22'h1);
        // Bottom when select bit 3 set, top otherwise
        if (full || ctl.bp[3]) begin
            ctl.lo = 21'h000000;
            ctl.hi = mask;
        end else begin
            ctl.lo = ~mask;
            ctl.hi = {21{1'b1}};
        end
    end
endmodule

/* verification/fswp_host_model.sv */
/*
 * Host-side model: hands whole decoded commands to the protection core.
 * Assumes the bench calls send from one process at a time.
 */
module fswp_host_model (
    // Clock
    input  wire logic        clk,
    // Command lines
    output logic             cmd_valid,
    output logic      [7:0]  cmd_op,
    output logic      [20:0] cmd_addr,
    output logic      [7:0]  cmd_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cmd_valid = 1'b0;
        cmd_op    = 8'h00;
        cmd_addr  = 21'h0;
        cmd_data  = 8'h00;
    end

    // One-cycle request; released lines show the inverse, not old values
    task automatic send(logic [7:0] op, logic [20:0] a, logic [7:0] d);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_op    = op;
        cmd_addr  = a;
        cmd_data  = d;
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_op    = ~op;
        cmd_addr  = ~a;
        cmd_data  = ~d;
    endtask
endmodule

/* verification/tb_flash_status_write_protect.sv */
/*
 * Self-checking bench of the status and protection core.
 * Assumes the host model drives on falling edges; answers are read
 * at the falling edge after the taking edge.
 */
module tb_flash_status_write_protect;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, rst, pwr_cycle, wp_n, engine_busy, program_active;
    logic        cmd_valid, quad_pins_on, four_wire_command_mode;
    logic        deep_power_down, pe_go, pe_refused;
    logic        sr_accepted, sr_refused;
    logic [7:0]  cmd_op, cmd_data;
    logic [20:0] cmd_addr;
    logic [23:0] status_word;
    logic [1:0]  drive_level;
    logic [2:0]  secreg_read_only;
    int          n_fail, n_checks, seed, cyc;
    int          lgs [4] = '{8, 12, 15, 16};

    fswp_host_model u_host (.clk, .cmd_valid, .cmd_op, .cmd_addr,
        .cmd_data);
    fswp_core u_dut (.clk, .rst, .cmd_valid, .cmd_op, .cmd_addr,
        .cmd_data, .pwr_cycle, .wp_n, .engine_busy, .program_active,
        .status_word, .quad_pins_on, .four_wire_command_mode,
        .drive_level, .deep_power_down, .secreg_read_only, .pe_go,
        .pe_refused, .sr_accepted, .sr_refused);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Checks and helpers
    // ------------------------------------------------------------------
    task automatic chk_bit(string nm, logic e, logic g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %b got %b", nm, e, g);
        end
    endtask

    task automatic chk_fld(string nm, logic [23:0] e, logic [23:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic op(logic [7:0] o);
        u_host.send(o, 21'h0, 8'h00);
    endtask

    task automatic wsr(int b, logic [7:0] d);
        op(fswp_pkg::OP_WREN);
        u_host.send(b == 1 ? fswp_pkg::OP_WRSR1 : b == 2 ?
            fswp_pkg::OP_WRSR2 : fswp_pkg::OP_WRSR3, 21'h0, d);
    endtask

    task automatic pwr();
        @(negedge clk);
        pwr_cycle = 1'b1;
        @(negedge clk);
        pwr_cycle = 1'b0;
    endtask

    function automatic logic [7:0] op_of(int k);
        case (k)
            0: return fswp_pkg::OP_PP;
            1: return fswp_pkg::OP_SE;
            2: return fswp_pkg::OP_BE32;
            3: return fswp_pkg::OP_BE64;
            4: return fswp_pkg::OP_CE_A;
            default: return fswp_pkg::OP_CE_B;
        endcase
    endfunction

    // Whole aligned span against guarded set; invert takes complement
    function automatic logic guard(logic [4:0] s, logic iv,
                                   logic [20:0] a, int lg);
        int lo, hi, sz, st, en;
        logic none;
        none = s[2:0] == 3'h0;
        sz = 32'h200000;
        if (s[2:1] != 2'h3 && !s[4]) sz = 32'h10000 << (s[2:0] - 1);
        if (s[2:1] != 2'h3 && s[4]) sz = s[2] ? 32'h8000 :
            32'h1000 << (s[2:0] - 1);
        lo = s[3] ? 0 : 32'h200000 - sz;
        hi = s[3] ? sz - 1 : 32'h1FFFFF;
        if (s[2:1] == 2'h3) lo = 0;
        st = (int'(a) >> lg) << lg;
        en = st + (1 << lg) - 1;
        if (!iv) return !none && en >= lo && st <= hi;
        return none || st < lo || en > hi;
    endfunction

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        int k;
        logic [4:0] s;
        logic iv, e;
        logic [20:0] a;
        seed = 32'h366b293c;
        rst = 1'b1;
        pwr_cycle = 1'b0;
        wp_n = 1'b1;
        engine_busy = 1'b0;
        program_active = 1'b0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk_fld("status", 24'h000000, status_word);
        op(fswp_pkg::OP_PP);
        chk_bit("pe_refused", 1'b1, pe_refused);
        u_host.send(fswp_pkg::OP_WRSR1, 21'h0, 8'h04);
        chk_bit("sr_refused", 1'b1, sr_refused);
        op(fswp_pkg::OP_WREN);
        chk_bit("latch", 1'b1, status_word[1]);
        op(fswp_pkg::OP_WRDI);
        chk_bit("latch", 1'b0, status_word[1]);
        op(fswp_pkg::OP_WREN);
        op(fswp_pkg::OP_RST_EN);
        op(fswp_pkg::OP_RST);
        chk_bit("latch", 1'b0, status_word[1]);
        op(fswp_pkg::OP_WREN);
        op(fswp_pkg::OP_RST);
        chk_bit("latch", 1'b1, status_word[1]);
        for (int i = 0; i < 48; i++) begin
            s = 5'($random(seed));
            iv = 1'($random(seed));
            a = 21'($random(seed));
            wp_n = 1'($random(seed));
            k = int'({$random(seed)} % 6);
            if (i < 2) begin
                s = i == 1 ? 5'h07 : 5'h00;
                iv = 1'(i);
                k = 4 + i;
            end
            wsr(2, 8'(iv) << 6);
            wsr(1, {1'b0, s, 2'h0});
            chk_fld("sel", 24'(s), 24'(status_word[6:2]));
            chk_bit("inv", iv, status_word[14]);
            e = k > 3 ? (s[2:0] == 3'h0 && !iv) || (s[2:0] == 3'h7 && iv)
                      : !guard(s, iv, a, lgs[k]);
            op(fswp_pkg::OP_WREN);
            u_host.send(k == 0 && a[0] ? fswp_pkg::OP_QPP : op_of(k), a,
                8'h00);
            chk_bit("pe_go", e, pe_go);
            chk_bit("pe_refused", !e, pe_refused);
            chk_bit("latch", 1'b0, status_word[1]);
        end
        wp_n = 1'b1;
        wsr(1, 8'h80);
        wp_n = 1'b0;
        wsr(1, 8'h84);
        chk_bit("sr_refused", 1'b1, sr_refused);
        chk_fld("sel", 24'h0, 24'(status_word[6:2]));
        wp_n = 1'b1;
        wsr(1, 8'h84);
        chk_bit("sr_accepted", 1'b1, sr_accepted);
        wsr(1, 8'h00);
        wsr(2, 8'h01);
        wsr(1, 8'h04);
        chk_bit("sr_refused", 1'b1, sr_refused);
        pwr();
        chk_fld("lock", 24'h0, 24'(status_word[8:7]));
        op(fswp_pkg::OP_QUAD_ON);
        chk_bit("four_wire", 1'b0, four_wire_command_mode);
        wsr(2, 8'h02); // Quad enable first, as the host must
        chk_bit("quad", 1'b1, quad_pins_on);
        op(fswp_pkg::OP_QUAD_ON);
        chk_bit("four_wire", 1'b1, four_wire_command_mode);
        wsr(2, 8'h00);
        chk_bit("quad", 1'b1, status_word[9]);
        op(fswp_pkg::OP_QUAD_OFF);
        wsr(2, 8'h00);
        chk_bit("quad", 1'b0, quad_pins_on);
        wsr(2, 8'h08);
        wsr(2, 8'h00);
        chk_fld("secreg", 24'h1, 24'(secreg_read_only));
        chk_fld("locks", 24'h1, 24'(status_word[13:11]));
        program_active = 1'b1;
        op(fswp_pkg::OP_SUSPEND);
        chk_bit("prog_pause", 1'b1, status_word[10]);
        op(fswp_pkg::OP_RESUME);
        chk_bit("prog_pause", 1'b0, status_word[10]);
        program_active = 1'b0;
        op(fswp_pkg::OP_SUSPEND);
        chk_bit("erase_pause", 1'b1, status_word[15]);
        pwr();
        chk_bit("erase_pause", 1'b0, status_word[15]);
        for (int d = 0; d < 4; d++) begin
            engine_busy = 1'(d);
            wsr(3, 8'(d << 5));
            chk_fld("drive", 24'(d), 24'(drive_level));
            chk_bit("busy", 1'(d), status_word[0]);
        end
        engine_busy = 1'b0;
        op(fswp_pkg::OP_SLEEP);
        chk_bit("sleep", 1'b1, deep_power_down);
        op(fswp_pkg::OP_WREN);
        chk_bit("latch", 1'b0, status_word[1]);
        op(fswp_pkg::OP_WAKE);
        chk_bit("sleep", 1'b0, deep_power_down);
        wsr(1, 8'h80);
        wsr(2, 8'h01);
        pwr();
        wsr(1, 8'h04);
        chk_bit("sr_refused", 1'b1, sr_refused);
        chk_fld("lock", 24'h3, 24'(status_word[8:7]));
        close_out();
    end
endmodule
